//--- hw/crcr_map.svh
`ifndef CRCR_MAP_SVH
`define CRCR_MAP_SVH

// Byte addresses of the register words
`define CRCR_ADDR_RESET_CTRL 16'h0804
`define CRCR_ADDR_STATUS 16'h0814
`define CRCR_ADDR_CLOCK_SEL 16'h1004
`define CRCR_ADDR_MODULE_DESCRIPTION 16'h10FC
`define CRCR_ADDR_CTRL 16'h1100
`define CRCR_ADDR_RESULT 16'h110C
`define CRCR_ADDR_RESULT_HALF 16'h1110

// Field positions
`define CRCR_STAT_STICKY_BIT 16
`define CRCR_CLOCK_SOURCE_SELECT_MCLK_BIT 0
`define CRCR_RESET_CONTROL_REGISTER_KEY_LSB 24
`define CRCR_RESET_CONTROL_REGISTER_KEY_VALUE 8'hB1
`define CRCR_RESET_CONTROL_REGISTER_CLEAR_BIT 1
`define CRCR_RESET_CONTROL_REGISTER_ASSERT_BIT 0
`define CRCR_CTRL_POLY_BIT 0
`define CRCR_CTRL_BITREV_BIT 1
`define CRCR_CTRL_ORDER_BIT 2
`define CRCR_CTRL_SWAP_BIT 4
`define CRCR_MODULE_DESCRIPTION_MODULE_LSB 16
`define CRCR_MODULE_DESCRIPTION_FEATURE_LSB 12
`define CRCR_MODULE_DESCRIPTION_INSTANCE_LSB 8
`define CRCR_MODULE_DESCRIPTION_MAJOR_LSB 4
`define CRCR_MODULE_DESCRIPTION_MINOR_LSB 0

// Reset values
`define CRCR_CLOCK_SOURCE_SELECT_RESET 32'h0000_0001
`define CRCR_ZERO_WORD 32'h0000_0000

// Bus answers
`define CRCR_RESP_OKAY 2'h0
`define CRCR_RESP_SLVERR 2'h2

`endif

//--- hw/crcr_pkg.sv
package crcr_pkg;

    typedef struct packed {
        logic poly_width_select;
        logic bit_reverse;
        logic input_byte_order;
        logic result_byte_swap;
    } crcr_ctrl_t;

    typedef struct packed {
        logic aw_held;
        logic [15:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        crcr_ctrl_t ctrl;
        logic reset_sticky_flag;
        logic soft_reset;
    } crcr_state_t;

endpackage

//--- hw/crcr_regs.sv
// Operation
// - Sticky flag bit 16 set on peripheral reset
// - Read-only clock select bit 0, resets 1
// - Identification word with five fixed fields
// - Instance field taken from a parameter
// - Half-word result read swaps two bytes
// - 32-bit word result read reverses four bytes
// - 16-bit swapped word read: 0,0,B0,B1
// - 16-bit unswapped word read: 0,0,B1,B0
// - Input byte order bit 2 selects processing
// - Bit 0 selects 32 or 16-bit polynomial
`timescale 1ns/1ps
`include "crcr_map.svh"

module crcr_regs
    import crcr_pkg::*;
#(
    parameter logic [15:0] MODULE_ID = 16'hA5C3,  // Arbitrary value
    parameter logic [3:0] FEATURE_VERSION = 4'h7,
    parameter logic [3:0] INSTANCE_INDEX = 4'h0,
    parameter logic [3:0] MAJOR_REVISION = 4'h1,
    parameter logic [3:0] MINOR_REVISION = 4'h0
)
(
    input wire logic mclk,  // Main clock
    input wire logic rst_n,  // Async reset
    input wire logic [15:0] s_axi_awaddr,  // Write address
    input wire logic s_axi_awvalid,  // Write address valid
    output logic s_axi_awready,  // Write address ready
    input wire logic [31:0] s_axi_wdata,  // Write data
    input wire logic [3:0] s_axi_wstrb,  // Write strobes
    input wire logic s_axi_wvalid,  // Write data valid
    output logic s_axi_wready,  // Write data ready
    output logic [1:0] s_axi_bresp,  // Write response
    output logic s_axi_bvalid,  // Write response valid
    input wire logic s_axi_bready,  // Write response ready
    input wire logic [15:0] s_axi_araddr,  // Read address
    input wire logic s_axi_arvalid,  // Read address valid
    output logic s_axi_arready,  // Read address ready
    output logic [31:0] s_axi_rdata,  // Read data
    output logic [1:0] s_axi_rresp,  // Read response
    output logic s_axi_rvalid,  // Read data valid
    input wire logic s_axi_rready,  // Read data ready
    input wire logic [31:0] checksum_value,  // Stored result from datapath
    output logic poly_width_select,  // 1 = 16-bit polynomial
    output logic bit_reverse,  // Bit order reversal
    output logic input_byte_order,  // 1 = LSB processed last
    output logic periph_soft_reset  // One-cycle peripheral reset pulse
);

    crcr_state_t state;
    crcr_state_t next_state;

    // Four bytes in reverse lane order
    function automatic logic [31:0] byte_reverse(input logic [31:0] v);
        byte_reverse = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    // Low two bytes exchanged, upper half zero
    function automatic logic [31:0] half_swap(input logic [31:0] v);
        half_swap = {16'h0000, v[7:0], v[15:8]};
    endfunction

    // Aligned word address, low bits ignored
    function automatic logic [15:0] word_addr(input logic [15:0] a);
        word_addr = {a[15:2], 2'b00};
    endfunction

    // Reset control write counts only with key and both lanes
    function automatic logic keyed_write(input logic [31:0] d, input logic [3:0] s);
        keyed_write = s[3] && s[0] && (d[`CRCR_RESET_CONTROL_REGISTER_KEY_LSB +: 8] == `CRCR_RESET_CONTROL_REGISTER_KEY_VALUE);
    endfunction

    // Full-word view of the result, stored value untouched
    function automatic logic [31:0] result_word(input logic [31:0] v, input crcr_ctrl_t c);
        logic [31:0] low;
        low = {16'h0000, v[15:0]};
        if (c.poly_width_select)
        begin
            if (c.result_byte_swap)
            begin
                result_word = half_swap(v);
            end
            else
            begin
                result_word = low;
            end
        end
        else if (c.result_byte_swap)
        begin
            result_word = byte_reverse(v);
        end
        else
        begin
            result_word = v;
        end
    endfunction

    // Half-word view of the result
    function automatic logic [31:0] result_half(input logic [31:0] v, input crcr_ctrl_t c);
        if (c.result_byte_swap)
        begin
            result_half = half_swap(v);
        end
        else
        begin
            result_half = {16'h0000, v[15:0]};
        end
    endfunction

    // Control word as software reads it
    function automatic logic [31:0] ctrl_word(input crcr_ctrl_t c);
        logic [31:0] w;
        w = `CRCR_ZERO_WORD;
        w[`CRCR_CTRL_POLY_BIT] = c.poly_width_select;
        w[`CRCR_CTRL_BITREV_BIT] = c.bit_reverse;
        w[`CRCR_CTRL_ORDER_BIT] = c.input_byte_order;
        w[`CRCR_CTRL_SWAP_BIT] = c.result_byte_swap;
        ctrl_word = w;
    endfunction

    // Identification fields fixed by parameters
    function automatic logic [31:0] module_description_word();
        logic [31:0] w;
        w = `CRCR_ZERO_WORD;
        w[`CRCR_MODULE_DESCRIPTION_MODULE_LSB +: 16] = MODULE_ID;
        w[`CRCR_MODULE_DESCRIPTION_FEATURE_LSB +: 4] = FEATURE_VERSION;
        w[`CRCR_MODULE_DESCRIPTION_INSTANCE_LSB +: 4] = INSTANCE_INDEX;
        w[`CRCR_MODULE_DESCRIPTION_MAJOR_LSB +: 4] = MAJOR_REVISION;
        w[`CRCR_MODULE_DESCRIPTION_MINOR_LSB +: 4] = MINOR_REVISION;
        module_description_word = w;
    endfunction

    always_comb
    begin
        logic [31:0] rd;
        logic rd_ok;
        logic key_ok;
        logic do_clear;
        logic do_assert;
        rd = `CRCR_ZERO_WORD;
        rd_ok = 1'b1;
        key_ok = 1'b0;
        do_clear = 1'b0;
        do_assert = 1'b0;
        // Every register except soft_reset holds unless a transfer moves it; soft_reset clears each cycle
        next_state = state;
        next_state.soft_reset = 1'b0;

        // Address and data taken in either order
        if (s_axi_awvalid && state.awready)
        begin
            next_state.aw_held = 1'b1;
            next_state.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state.wready)
        begin
            next_state.w_held = 1'b1;
            next_state.wdata = s_axi_wdata;
            next_state.wstrb = s_axi_wstrb;
        end
        // Write response leaves at the bready handshake
        if (state.bvalid && s_axi_bready)
        begin
            next_state.bvalid = 1'b0;
        end

        // Commit once both halves are held
        if (state.aw_held && state.w_held && !state.bvalid)
        begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = `CRCR_RESP_OKAY;
            case (word_addr(state.awaddr))
                `CRCR_ADDR_CTRL:
                begin
                    if (state.wstrb[0])
                    begin
                        next_state.ctrl.poly_width_select = state.wdata[`CRCR_CTRL_POLY_BIT];
                        next_state.ctrl.bit_reverse = state.wdata[`CRCR_CTRL_BITREV_BIT];
                        next_state.ctrl.input_byte_order = state.wdata[`CRCR_CTRL_ORDER_BIT];
                        next_state.ctrl.result_byte_swap = state.wdata[`CRCR_CTRL_SWAP_BIT];
                    end
                end
                `CRCR_ADDR_RESET_CTRL:
                begin
                    // Writes without the key leave flag and reset alone
                    key_ok = keyed_write(state.wdata, state.wstrb);
                    do_clear = key_ok && state.wdata[`CRCR_RESET_CONTROL_REGISTER_CLEAR_BIT];
                    do_assert = key_ok && state.wdata[`CRCR_RESET_CONTROL_REGISTER_ASSERT_BIT];
                end
                `CRCR_ADDR_STATUS, `CRCR_ADDR_CLOCK_SEL, `CRCR_ADDR_MODULE_DESCRIPTION,
                `CRCR_ADDR_RESULT, `CRCR_ADDR_RESULT_HALF:
                begin
                    // Read-only words take the write without effect
                    next_state.bresp = `CRCR_RESP_OKAY;
                end
                default:
                begin
                    // Unmapped words answer with an error
                    next_state.bresp = `CRCR_RESP_SLVERR;
                end
            endcase
        end

        // Set wins over clear in the same write
        if (do_clear)
        begin
            next_state.reset_sticky_flag = 1'b0;
        end
        if (do_assert)
        begin
            next_state.reset_sticky_flag = 1'b1;
            next_state.soft_reset = 1'b1;
            // Peripheral reset returns control to its reset value
            next_state.ctrl = '0;
        end

        // Read response leaves at the rready handshake
        if (state.rvalid && s_axi_rready)
        begin
            next_state.rvalid = 1'b0;
        end
        // Read data captured at the address handshake
        if (s_axi_arvalid && state.arready)
        begin
            case (word_addr(s_axi_araddr))
                `CRCR_ADDR_STATUS:
                begin
                    rd[`CRCR_STAT_STICKY_BIT] = state.reset_sticky_flag;
                end
                `CRCR_ADDR_CLOCK_SEL:
                begin
                    rd = `CRCR_CLOCK_SOURCE_SELECT_RESET;
                end
                `CRCR_ADDR_MODULE_DESCRIPTION:
                begin
                    rd = module_description_word();
                end
                `CRCR_ADDR_CTRL:
                begin
                    rd = ctrl_word(state.ctrl);
                end
                `CRCR_ADDR_RESULT:
                begin
                    rd = result_word(checksum_value, state.ctrl);
                end
                `CRCR_ADDR_RESULT_HALF:
                begin
                    rd = result_half(checksum_value, state.ctrl);
                end
                `CRCR_ADDR_RESET_CTRL:
                begin
                    rd = `CRCR_ZERO_WORD;
                end
                default:
                begin
                    // Unmapped reads return zero with an error
                    rd_ok = 1'b0;
                end
            endcase
            next_state.rvalid = 1'b1;
            next_state.rdata = rd;
            next_state.rresp = rd_ok ? `CRCR_RESP_OKAY : `CRCR_RESP_SLVERR;
        end

        // One item of each kind in flight
        next_state.awready = !next_state.aw_held && !next_state.bvalid;
        next_state.wready = !next_state.w_held && !next_state.bvalid;
        next_state.arready = !next_state.rvalid;
    end

    // Whole state reset together, asynchronously
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Outputs taken straight from the state register
    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;
    assign poly_width_select = state.ctrl.poly_width_select;
    assign bit_reverse = state.ctrl.bit_reverse;
    assign input_byte_order = state.ctrl.input_byte_order;
    assign periph_soft_reset = state.soft_reset;

endmodule

//--- verif/crcr_regs_asserts.sv
`timescale 1ns/1ps
`include "crcr_map.svh"
module crcr_regs_asserts
    import crcr_pkg::*;
#(
    parameter logic [15:0] MODULE_ID = 16'hA5C3,
    parameter logic [3:0] FEATURE_VERSION = 4'h7,
    parameter logic [3:0] INSTANCE_INDEX = 4'h0,
    parameter logic [3:0] MAJOR_REVISION = 4'h1,
    parameter logic [3:0] MINOR_REVISION = 4'h0
)
(
    input wire logic mclk,  // Clock
    input wire logic rst_n,  // Async reset
    input wire logic [15:0] s_axi_awaddr,  // Write address
    input wire logic s_axi_awvalid,  // Write address valid
    input wire logic s_axi_awready,  // Write address ready
    input wire logic [31:0] s_axi_wdata,  // Write data
    input wire logic [3:0] s_axi_wstrb,  // Write strobes
    input wire logic s_axi_wvalid,  // Write data valid
    input wire logic s_axi_wready,  // Write data ready
    input wire logic [1:0] s_axi_bresp,  // Write response
    input wire logic s_axi_bvalid,  // Write response valid
    input wire logic s_axi_bready,  // Write response ready
    input wire logic [15:0] s_axi_araddr,  // Read address
    input wire logic s_axi_arvalid,  // Read address valid
    input wire logic s_axi_arready,  // Read address ready
    input wire logic [31:0] s_axi_rdata,  // Read data
    input wire logic [1:0] s_axi_rresp,  // Read response
    input wire logic s_axi_rvalid,  // Read data valid
    input wire logic s_axi_rready,  // Read data ready
    input wire logic [31:0] checksum_value,  // Stored result
    input wire logic poly_width_select,  // Polynomial width
    input wire logic bit_reverse,  // Bit reversal
    input wire logic input_byte_order,  // Input byte order
    input wire logic periph_soft_reset  // Peripheral reset pulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire ar_take = s_axi_arvalid && s_axi_arready;
    property p_clock_source_select;
        ar_take && s_axi_araddr == `CRCR_ADDR_CLOCK_SEL |=> s_axi_rdata == `CRCR_CLOCK_SOURCE_SELECT_RESET;
    endproperty
    a_clock_source_select: assert property (p_clock_source_select)
        else $error("clock select read wrong");
    property p_module_description;
        ar_take && s_axi_araddr == `CRCR_ADDR_MODULE_DESCRIPTION |=> s_axi_rdata ==
            {MODULE_ID, FEATURE_VERSION, INSTANCE_INDEX, MAJOR_REVISION, MINOR_REVISION};
    endproperty
    a_module_description: assert property (p_module_description)
        else $error("description read wrong");
    property p_stat;
        ar_take && s_axi_araddr == `CRCR_ADDR_STATUS |=>
            s_axi_rdata[31:17] == 15'h0000 && s_axi_rdata[15:0] == 16'h0000;
    endproperty
    a_stat: assert property (p_stat)
        else $error("status reserved bits set");
    property p_half;
        ar_take && s_axi_araddr == `CRCR_ADDR_RESULT && poly_width_select |=>
            s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_half: assert property (p_half)
        else $error("upper result half not zero");
    property p_poly;
        $changed(poly_width_select) |-> $rose(s_axi_bvalid);
    endproperty
    a_poly: assert property (p_poly)
        else $error("width select moved without a write");
    property p_order;
        $changed(input_byte_order) |-> $rose(s_axi_bvalid);
    endproperty
    a_order: assert property (p_order)
        else $error("byte order moved without a write");
    property p_pulse;
        periph_soft_reset |=> (!periph_soft_reset) [*3];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("soft reset pulse too long");
    property p_soft;
        periph_soft_reset |-> s_axi_bvalid && !poly_width_select && !input_byte_order
            && !bit_reverse;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset without write or control kept");
    c_soft: cover property (periph_soft_reset);
    c_half: cover property (ar_take && s_axi_araddr == `CRCR_ADDR_RESULT_HALF);
    c_poly: cover property ($rose(poly_width_select));
endmodule
bind crcr_regs crcr_regs_asserts #(.MODULE_ID(MODULE_ID), .FEATURE_VERSION(FEATURE_VERSION),
    .INSTANCE_INDEX(INSTANCE_INDEX), .MAJOR_REVISION(MAJOR_REVISION),
    .MINOR_REVISION(MINOR_REVISION)) u_chk (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .checksum_value(checksum_value),
    .poly_width_select(poly_width_select), .bit_reverse(bit_reverse),
    .input_byte_order(input_byte_order), .periph_soft_reset(periph_soft_reset)
);

//--- verif/crcr_tb.sv
`timescale 1ns/1ps
`include "crcr_map.svh"
module testbench;
    import crcr_pkg::*;
    localparam logic [15:0] ID = 16'h5A3C;  // Arbitrary value
    localparam logic [3:0] INST = 4'h5;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s: expected %h, seen %h", n, e, g); end end
    logic mclk = 1'h0, rst_n = 1'h0;
    logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_data, checksum_value = 32'h1122_3344;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic poly_width_select, bit_reverse, input_byte_order, periph_soft_reset;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    int errors = 0, check_count = 0, cycles = 0, pulses = 0;
    crcr_regs #(.MODULE_ID(ID), .INSTANCE_INDEX(INST)) uut (
        .mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .checksum_value(checksum_value),
        .poly_width_select(poly_width_select), .bit_reverse(bit_reverse),
        .input_byte_order(input_byte_order), .periph_soft_reset(periph_soft_reset)
    );
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (periph_soft_reset === 1'h1)
            pulses++;
        if (cycles == 3000)
        begin
            errors++;
            results;
        end
    end
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task t_ident;
        rd(`CRCR_ADDR_MODULE_DESCRIPTION);
        `CHK("module_description", {ID, 4'h7, INST, 4'h1, 4'h0}, rd_data)
        rd(`CRCR_ADDR_STATUS);
        `CHK("status", 32'h0000_0000, rd_data)
        wr(`CRCR_ADDR_CLOCK_SEL, 32'h0000_0000, 4'hF);
        `CHK("clock_source_select bresp", 2'h0, wr_resp)
        rd(`CRCR_ADDR_CLOCK_SEL);
        `CHK("clock_source_select", 32'h0000_0001, rd_data)
        rd(16'h1200);
        `CHK("unmapped", 2'h2, rd_resp)
        `CHK("unmapped data", 32'h0000_0000, rd_data)
        wr(16'h1200, 32'hFFFF_FFFF, 4'hF);
        `CHK("unmapped bresp", 2'h2, wr_resp)
        $display("test ident done");
    endtask
    task t_order;
        wr(`CRCR_ADDR_CTRL, 32'h0000_0006, 4'h1);
        `CHK("order", 1'h1, input_byte_order)
        `CHK("bitrev", 1'h1, bit_reverse)
        wr(`CRCR_ADDR_CTRL, 32'h0000_0000, 4'hE);
        rd(`CRCR_ADDR_CTRL);
        `CHK("ctrl", 32'h0000_0006, rd_data)
        $display("test order done");
    endtask
    task t_result;
        logic [31:0] ctl [4] = '{32'h00, 32'h10, 32'h01, 32'h11};
        logic [31:0] ew [4] = '{32'h1122_3344, 32'h4433_2211, 32'h3344, 32'h4433};
        for (int i = 0; i < 4; i++)
        begin
            wr(`CRCR_ADDR_CTRL, ctl[i], 4'hF);
            `CHK("poly", ctl[i][0], poly_width_select)
            rd(`CRCR_ADDR_RESULT);
            `CHK("word", ew[i], rd_data)
            rd(`CRCR_ADDR_RESULT_HALF);
            `CHK("half", ctl[i][4] ? 32'h4433 : 32'h3344, rd_data)
        end
        $display("test result done");
    endtask
    task t_sticky;
        wr(`CRCR_ADDR_RESET_CTRL, 32'hA100_0001, 4'hF);
        rd(`CRCR_ADDR_STATUS);
        `CHK("bad key", 32'h0000_0000, rd_data)
        wr(`CRCR_ADDR_RESET_CTRL, 32'hB100_0001, 4'hF);
        rd(`CRCR_ADDR_STATUS);
        `CHK("sticky", 32'h0001_0000, rd_data)
        `CHK("pulses", 1, pulses)
        `CHK("ctrl clr", 1'h0, poly_width_select)
        wr(`CRCR_ADDR_RESET_CTRL, 32'hA100_0002, 4'hF);
        rd(`CRCR_ADDR_STATUS);
        `CHK("kept", 32'h0001_0000, rd_data)
        wr(`CRCR_ADDR_RESET_CTRL, 32'hB100_0002, 4'hF);
        rd(`CRCR_ADDR_STATUS);
        `CHK("cleared", 32'h0000_0000, rd_data)
        wr(`CRCR_ADDR_RESET_CTRL, 32'hB100_0003, 4'hF);
        rd(`CRCR_ADDR_STATUS);
        `CHK("set wins", 32'h0001_0000, rd_data)
        `CHK("pulses", 2, pulses)
        $display("test sticky done");
    endtask
    task results;
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (2) @(posedge mclk);
        t_ident;
        t_order;
        t_result;
        t_sticky;
        results;
    end
endmodule
